// *** ltmc_defs.vh ***
// constants for the lin transceiver mode control block
`ifndef LTMC_DEFS_VH
`define LTMC_DEFS_VH

// mode encodings, one-hot
`define LTMC_MODE_SLEEP    3'h1
`define LTMC_MODE_STANDBY  3'h2
`define LTMC_MODE_NORMAL   3'h4

// clock period in ns
`define LTMC_CLK_NS        8
// filter and timeout times in us
`define LTMC_LWAKE_US      50
`define LTMC_BWAKE_US      100
`define LTMC_DOM_US        20000

// fifo shape
`define LTMC_FIFO_W        1
`define LTMC_FIFO_D        16
`define LTMC_FIFO_AW       4

`endif

// *** ltmc_fifo.v ***
// holds no logic: the receive sample fifo module stands beside the top module in ltmc_top.v

// *** ltmc_top.v ***
// mode, wake-up and protection control of a lin transceiver
// Operation
// - normal mode: tx low drives bus dominant
// - normal mode: rx follows bus level
// - standby holds rx output low
// - local wake: tx pulled low in standby
// - enable high gives normal mode
// - enable low in normal mode gives sleep mode
// - normal reached from sleep directly or after wake; enable defaults low (enable_i has no pull here; power-up mode follows its driven level)
// - local wake needs filtered long low
// - wake detection active during sleep
// - regulator control on in normal
// - regulator control released in sleep
// - wake in sleep: standby, regulator on
// - standby: transmitter off, regulator on, wait
// - normal mode carries bus data freely
// - thermal shutdown disables transmitter
// - any fault disables transmitter until clear
// - dominant timeout guards stuck tx
// - timer starts falling, clears on rising
// - bus wake: dominant filter then recessive
// - tx shows wake source in standby
// - power-up mode follows enable level
`timescale 1ns/1ps
`default_nettype none
`include "ltmc_defs.vh"

module ltmc_top #(
  parameter LWAKE_CYC = (`LTMC_LWAKE_US * 1000 + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS,
  parameter BWAKE_CYC = (`LTMC_BWAKE_US * 1000 + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS,
  parameter DOM_CYC   = (`LTMC_DOM_US * 1000) / `LTMC_CLK_NS
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_i,
  // host side
  input  wire        enable_i,
  input  wire        tx_data_i,
  output reg         tx_data_o,
  output reg         tx_data_oe_o,
  output reg         bus_state_o,
  output reg         bus_state_oe_o,
  // bus side
  input  wire        lin_bus_i,
  output reg         lin_bus_o,
  output reg         lin_bus_oe_o,
  // local wake and regulator
  input  wire        local_wake_n_i,
  output reg         regulator_ctrl_o,
  output reg         regulator_ctrl_oe_o,
  // faults
  input  wire        undervoltage_i,
  input  wire        overtemp_i,
  input  wire        ground_loss_i,
  // status
  output reg         dom_timeout_o,
  output reg         fifo_ready_o
);

  localparam CW = 22;
  localparam [2:0] S_SLEEP   = `LTMC_MODE_SLEEP;
  localparam [2:0] S_STANDBY = `LTMC_MODE_STANDBY;
  localparam [2:0] S_NORMAL  = `LTMC_MODE_NORMAL;

  // saturating counter step
  function [CW-1:0] cnt_step;
    input [CW-1:0] cnt;
    input          run;
    input [CW-1:0] lim;
    begin
      if (!run) begin
        cnt_step = {CW{1'b0}};
      end else if (cnt < lim) begin
        cnt_step = cnt + 1'b1;
      end else begin
        cnt_step = cnt;
      end
    end
  endfunction

  reg [2:0]    mode_r;
  reg [2:0]    mode_nxt;
  reg          init_r;
  reg          local_src_r;
  reg          tx_prev_r;
  reg          bus_prev_r;
  reg          dom_trip_r;
  reg          bus_dom_seen_r;
  reg [CW-1:0] lw_cnt_r;
  reg [CW-1:0] bw_cnt_r;
  reg [CW-1:0] dom_cnt_r;
  wire         fault;
  wire         local_wake;
  wire         bus_wake;
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire         fifo_out_data;

  // ----------------------------------------
  // wake filters
  // ----------------------------------------
  // counted filters
  assign local_wake = (lw_cnt_r >= LWAKE_CYC[CW-1:0]);
  assign bus_wake   = bus_dom_seen_r & lin_bus_i & ~bus_prev_r;
  assign fault      = undervoltage_i | overtemp_i | ground_loss_i;

  // ----------------------------------------
  // mode machine
  // ----------------------------------------
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      S_SLEEP: begin
        if (enable_i) begin
          mode_nxt = S_NORMAL;
        end else if (local_wake | bus_wake) begin
          mode_nxt = S_STANDBY;
        end
      end
      S_STANDBY: begin
        if (enable_i) begin
          mode_nxt = S_NORMAL;
        end
      end
      S_NORMAL: begin
        if (!enable_i) begin
          mode_nxt = S_SLEEP;
        end
      end
      default: begin
        mode_nxt = S_SLEEP;
      end
    endcase
    if (!init_r) begin
      mode_nxt = enable_i ? S_NORMAL : S_STANDBY;
    end
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode_r         <= S_SLEEP;
      init_r         <= 1'b0;
      local_src_r    <= 1'b0;
      tx_prev_r      <= 1'b1;
      bus_prev_r     <= 1'b1;
      dom_trip_r     <= 1'b0;
      bus_dom_seen_r <= 1'b0;
      lw_cnt_r       <= {CW{1'b0}};
      bw_cnt_r       <= {CW{1'b0}};
      dom_cnt_r      <= {CW{1'b0}};
    end else begin
      init_r     <= 1'b1;
      mode_r     <= mode_nxt;
      tx_prev_r  <= tx_data_i;
      bus_prev_r <= lin_bus_i;
      lw_cnt_r   <= cnt_step(lw_cnt_r, ~local_wake_n_i & (mode_r == S_SLEEP),
                             LWAKE_CYC[CW-1:0]);
      bw_cnt_r   <= cnt_step(bw_cnt_r, ~lin_bus_i & (mode_r == S_SLEEP),
                             BWAKE_CYC[CW-1:0]);
      if (mode_r != S_SLEEP) begin
        bus_dom_seen_r <= 1'b0;
      end else if (lin_bus_i) begin
        // a dominant that ended before the filter ran out must not arm a later wake
        bus_dom_seen_r <= 1'b0;
      end else if (bw_cnt_r >= BWAKE_CYC[CW-1:0]) begin
        bus_dom_seen_r <= 1'b1;
      end
      if (mode_r == S_SLEEP && mode_nxt == S_STANDBY) begin
        local_src_r <= local_wake;
      end else if (mode_nxt != S_STANDBY) begin
        local_src_r <= 1'b0;
      end
      if (tx_data_i & ~tx_prev_r) begin
        dom_cnt_r  <= {CW{1'b0}};
        dom_trip_r <= 1'b0;
      end else if (~tx_data_i & (mode_r == S_NORMAL)) begin
        dom_cnt_r <= cnt_step(dom_cnt_r, 1'b1, DOM_CYC[CW-1:0]);
        if (dom_cnt_r >= DOM_CYC[CW-1:0]) begin
          dom_trip_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // receive sample buffer
  // ----------------------------------------
  ltmc_fifo #(
    .W  (`LTMC_FIFO_W),
    .D  (`LTMC_FIFO_D),
    .AW (`LTMC_FIFO_AW)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (mode_r == S_NORMAL),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (lin_bus_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lin_bus_o           <= 1'b1;
      lin_bus_oe_o        <= 1'b0;
      bus_state_o         <= 1'b0;
      bus_state_oe_o      <= 1'b0;
      tx_data_o           <= 1'b0;
      tx_data_oe_o        <= 1'b0;
      regulator_ctrl_o    <= 1'b0;
      regulator_ctrl_oe_o <= 1'b0;
      dom_timeout_o       <= 1'b0;
      fifo_ready_o        <= 1'b0;
    end else begin
      lin_bus_o     <= 1'b0;
      dom_timeout_o <= dom_trip_r;
      fifo_ready_o  <= fifo_in_ready;
      // faults force transmitter off
      // our own standby pull on tx is not host data
      lin_bus_oe_o <= (mode_nxt == S_NORMAL) & ~tx_data_i & ~fault & ~dom_trip_r &
                      ~tx_data_oe_o;
      bus_state_o    <= 1'b0;
      bus_state_oe_o <= (mode_nxt == S_STANDBY) |
                        ((mode_nxt == S_NORMAL) & fifo_out_valid & ~fifo_out_data);
      tx_data_o    <= 1'b0;
      tx_data_oe_o <= (mode_nxt == S_STANDBY) &
                      (local_src_r | (mode_r == S_SLEEP & local_wake));
      regulator_ctrl_o    <= (mode_nxt != S_SLEEP);
      regulator_ctrl_oe_o <= (mode_nxt != S_SLEEP);
    end
  end

endmodule

// ----------------------------------------
// receive sample fifo
// ----------------------------------------
module ltmc_fifo #(
  parameter W  = 1,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire          clk_sys_i,
  input  wire          reset_i,
  // fill side
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  // drain side
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   count_r;
  wire         do_wr;
  wire         do_rd;

  assign in_ready_o  = (count_r != D);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_r];
  assign do_wr       = in_valid_i & in_ready_o;
  assign do_rd       = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** ltmc_monitor.sv ***
// port assertions for the lin mode control block
`timescale 1ns/1ps
`default_nettype none
module ltmc_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // inputs
  input wire logic enable_i,
  input wire logic tx_data_i,
  input wire logic lin_bus_i,
  input wire logic undervoltage_i,
  input wire logic overtemp_i,
  input wire logic ground_loss_i,
  // outputs watched
  input wire logic tx_data_o,
  input wire logic tx_data_oe_o,
  input wire logic bus_state_o,
  input wire logic bus_state_oe_o,
  input wire logic lin_bus_oe_o,
  input wire logic regulator_ctrl_o,
  input wire logic regulator_ctrl_oe_o,
  input wire logic dom_timeout_o
);
  logic [2:0] en_run_r;
  // consecutive samples with enable high, cleared when enable is low, saturating at four
  always @(posedge clk_sys_i or posedge reset_i)
    if (reset_i) en_run_r <= 3'h0;
    else if (!enable_i) en_run_r <= 3'h0;
    else if (en_run_r != 3'h4) en_run_r <= en_run_r + 3'h1;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  fault_tx_off_a:
  assert property ((undervoltage_i | overtemp_i | ground_loss_i) |=> !lin_bus_oe_o)
    else $error("bus driven during fault");
  timeout_tx_off_a:
  assert property (dom_timeout_o |-> !lin_bus_oe_o) else $error("bus driven after timeout");
  tx_rise_clear_a:
  assert property ($rose(tx_data_i) |=> ##1 !dom_timeout_o) else $error("timeout not cleared");
  drive_from_tx_a:
  assert property (lin_bus_oe_o |-> $past(enable_i && !tx_data_i))
    else $error("bus driven without tx low in normal");
  rx_follows_bus_a:
  assert property (en_run_r == 3'h4 |-> bus_state_oe_o == !$past(lin_bus_i, 2))
    else $error("rx not following bus");
  enable_normal_a:
  assert property (enable_i |=> regulator_ctrl_oe_o && regulator_ctrl_o && !tx_data_oe_o)
    else $error("enable high did not give normal");
  sleep_entry_a:
  assert property ($fell(enable_i) && regulator_ctrl_oe_o |=> !regulator_ctrl_oe_o)
    else $error("regulator still driven in sleep");
  pull_values_a:
  assert property (!bus_state_o && !tx_data_o) else $error("open drain data not low");
  wake_source_a:
  assert property (tx_data_oe_o |-> bus_state_oe_o && regulator_ctrl_o && !$past(enable_i))
    else $error("tx pull outside standby");
endmodule
bind ltmc_top ltmc_monitor mon_u (.*);
`default_nettype wire

// *** ltmc_host_model.sv ***
// host controller model: sends one frame on tx and reads rx back
`timescale 1ns/1ps
`default_nettype none
module ltmc_host_model #(
  parameter BIT_CYC = 8
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rx_wire_i,
  output var  logic       tx_o,
  output var  logic [7:0] rx_byte_o
);
  logic [9:0] got_r;
  initial begin
    tx_o = 1'b1;
    rx_byte_o = 8'h00;
    got_r = 10'h000;
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys_i);
      tx_o = frame[i];
      repeat (BIT_CYC - 3) @(negedge clk_sys_i);
      got_r[i] = rx_wire_i;
      repeat (2) @(negedge clk_sys_i);
    end
    rx_byte_o = got_r[8:1];
  endtask
endmodule
`default_nettype wire

// *** tb_lin_transceiver_mode_control.sv ***
// self-checking bench for the lin mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_lin_transceiver_mode_control;
  localparam LW = 8, BW = 8, DC = 100;
  logic clk_sys_i, reset_i, enable_i, node_drv, local_wake_n_i;
  logic [2:0] flt;
  logic [7:0] b;
  logic [31:0] lfsr = 32'ha6ec;
  int miscompares = 0, num_checks = 0;
  wire host_tx, tx_data_o, tx_data_oe_o, bus_state_o, bus_state_oe_o, lin_bus_oe_o;
  wire regulator_ctrl_o, regulator_ctrl_oe_o, dom_timeout_o, fifo_ready_o, lin_bus_dat;
  wire [7:0] rx_byte;
  // open drain and pulled wires resolved here
  wire tx_w = tx_data_oe_o ? tx_data_o : host_tx;
  wire bus_w = lin_bus_oe_o ? lin_bus_dat : node_drv;
  wire rx_w = bus_state_oe_o ? bus_state_o : 1'b1;
  ltmc_top #(.LWAKE_CYC(LW), .BWAKE_CYC(BW), .DOM_CYC(DC)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .enable_i(enable_i), .tx_data_i(tx_w),
    .tx_data_o(tx_data_o), .tx_data_oe_o(tx_data_oe_o), .bus_state_o(bus_state_o),
    .bus_state_oe_o(bus_state_oe_o), .lin_bus_i(bus_w), .lin_bus_o(lin_bus_dat),
    .lin_bus_oe_o(lin_bus_oe_o), .local_wake_n_i(local_wake_n_i),
    .regulator_ctrl_o(regulator_ctrl_o), .regulator_ctrl_oe_o(regulator_ctrl_oe_o),
    .undervoltage_i(flt[0]), .overtemp_i(flt[1]), .ground_loss_i(flt[2]),
    .dom_timeout_o(dom_timeout_o), .fifo_ready_o(fifo_ready_o));
  ltmc_host_model host_u (.clk_sys_i(clk_sys_i), .rx_wire_i(rx_w), .tx_o(host_tx),
    .rx_byte_o(rx_byte));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    cyc(100000);
    $display("Error watchdog expected end seen hang");
    miscompares++;
    finish_test;
  end
  initial begin
    {reset_i, enable_i, node_drv, local_wake_n_i, flt} = 7'h58;
    cyc(20);
    reset_i = 1'b0;
    cyc(2);
    chk("power-up standby", 1'b1, regulator_ctrl_oe_o & regulator_ctrl_o);
    chk("rx wake request", 1'b0, rx_w);
    enable_i = 1'b1;
    cyc(2);
    chk("fifo ready", 1'b1, fifo_ready_o);
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      b = (i == 0) ? 8'h00 : lfsr[7:0];
      host_u.send_byte(b);
      chk("loopback byte", b, rx_byte);
    end
    host_u.tx_o = 1'b0;
    cyc(DC - 10);
    chk("drive before timeout", 1'b1, lin_bus_oe_o & ~dom_timeout_o);
    cyc(14);
    chk("timeout tripped", 1'b1, dom_timeout_o & ~lin_bus_oe_o);
    host_u.tx_o = 1'b1;
    cyc(2);
    chk("timeout cleared", 1'b0, dom_timeout_o);
    chk("mode kept", 1'b1, regulator_ctrl_oe_o);
    host_u.tx_o = 1'b0;
    for (int f = 0; f < 3; f++) begin
      cyc(2);
      flt = 3'h1 << f;
      cyc(1);
      chk("fault tx off", 1'b0, lin_bus_oe_o);
      flt = 3'h0;
      cyc(2);
      chk("fault cleared", 1'b1, lin_bus_oe_o);
    end
    host_u.tx_o = 1'b1;
    enable_i = 1'b0;
    cyc(2);
    chk("sleep regulator", 1'b0, regulator_ctrl_oe_o | bus_state_oe_o);
    local_wake_n_i = 1'b0;
    cyc(LW - 2);
    local_wake_n_i = 1'b1;
    cyc(3);
    chk("short local pulse", 1'b0, regulator_ctrl_oe_o);
    local_wake_n_i = 1'b0;
    cyc(LW + 4);
    local_wake_n_i = 1'b1;
    cyc(6);
    chk("local wake", 1'b1, regulator_ctrl_oe_o & regulator_ctrl_o);
    chk("tx source low", 1'b0, tx_w);
    enable_i = 1'b1;
    cyc(2);
    chk("tx released", 1'b1, tx_w);
    enable_i = 1'b0;
    cyc(2);
    for (int k = 0; k < 2; k++) begin
      node_drv = 1'b0;
      cyc(k ? BW + 4 : BW - 2);
      chk("no wake while low", 1'b0, regulator_ctrl_oe_o);
      node_drv = 1'b1;
      cyc(4);
      chk("bus wake", 8'(k), regulator_ctrl_oe_o);
    end
    chk("tx source high", 1'b1, tx_w);
    enable_i = 1'b1;
    cyc(2);
    enable_i = 1'b0;
    cyc(2);
    enable_i = 1'b1;
    cyc(2);
    chk("enable wake", 1'b1, regulator_ctrl_oe_o & ~tx_data_oe_o);
    finish_test;
  end
endmodule
`default_nettype wire
